// [dpci_defs.svh]
/*
 * Timing counts and reset values for the drive panel control block.
 * Assumes a 40 MHz clock; included by bare name.
 */
`ifndef DPCI_DEFS_SVH
`define DPCI_DEFS_SVH

// Clock period in picoseconds
`define DPCI_CLK_PERIOD_PS 25000
// Write-inhibit switch debounce time in microseconds
`define DPCI_DEBOUNCE_US 5000
// Debounce time in clock cycles; worked in nanoseconds so no term passes 32 bits
`define DPCI_DEBOUNCE_CYC ((`DPCI_DEBOUNCE_US * 1000) / (`DPCI_CLK_PERIOD_PS / 1000))
// Reset value of the write-inhibit latch
`define DPCI_PROT_RST 1'b0

`endif

// [dpci_pkg.sv]
/*
 * Types shared by the drive panel control block.
 * Assumes the timing macros of dpci_defs.svh.
 */
package dpci_pkg;

    // Run/load sequencing states
    typedef enum logic [2:0] {
        DPCI_IDLE,
        DPCI_SPIN_UP,
        DPCI_HEAD_LOAD,
        DPCI_RUNNING,
        DPCI_SPIN_DOWN,
        DPCI_STOPPED
    } dpci_seq_e;

    // Drive mechanics status
    typedef struct packed {
        logic interlocks_safe;
        logic at_speed;
        logic stopped;
        logic heads_loaded;
        logic heads_retracted;
        logic seek_busy;
        logic heads_settled;
        logic transducer_fail;
        logic erase_current;
        logic write_current;
    } dpci_mech_s;

    // Lamp bundle
    typedef struct packed {
        logic ready;
        logic heads_settled_lamp;
        logic fault;
        logic protect;
        logic load;
        logic write_activity_lamp;
        logic read_activity;
        logic power_present_lamp;
    } dpci_lamps_s;

    // Drive mechanics commands
    typedef struct packed {
        logic door_lock;
        logic spindle_on;
        logic heads_forward;
        logic heads_unload;
    } dpci_cmd_s;

endpackage

// [dpci_panel.sv]
/*
 * Operator panel sequencing and indicator logic of a cartridge disk drive.
 * Assumes switches and mechanics status arrive asynchronously and are
 * synchronised here; host and write-path strobes are on clk_in.
 */
`timescale 1ns/1ps
`include "dpci_defs.svh"

// Function
// - Run: lock door, spin, load, ready
// - Load: unload, stop, unlock, load lamp
// - Run entry drives heads forward
// - First press sets protection, clears fault
// - Second press clears protection
// - Host command sets protection
// - Load-then-run clears protection
// - Ready needs speed, heads, interlocks
// - Ready drops at load switch
// - On-cylinder needs ready, idle, settled
// - On-cylinder off during seek
// - Fault on stray write current
// - Fault on transducer lamp failure
// - Fault holds until press or recycle
// - Load lamp: retracted and stopped
// - Write lamp follows write operation
// - Read lamp follows read operation
// - Power lamp follows operating power
module dpci_panel
    import dpci_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `DPCI_DEBOUNCE_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    // Panel switches (asynchronous)
    input  wire logic        run_sel_in,
    input  wire logic        write_inhibit_toggle_in,
    // Drive mechanics status (asynchronous)
    input  wire dpci_mech_s  mech_in,
    input  wire logic        power_ok_in,
    // Same-clock strobes from host and data path
    input  wire logic        host_protect_in,
    input  wire logic        write_gate_in,
    input  wire logic        read_active_in,
    // Mechanics commands
    output dpci_cmd_s        cmd_out,
    // Lamps, also the write block for the data path
    output dpci_lamps_s      lamps_out
);

    localparam int CW = $clog2(DEBOUNCE_CYC + 1);
    localparam int NS = 13;

    // Two-stage synchroniser for every asynchronous input
    logic [NS-1:0] async_w;
    logic [NS-1:0] s1_reg;
    logic [NS-1:0] s2_reg;
    assign async_w = {run_sel_in, write_inhibit_toggle_in, power_ok_in, mech_in};

    // Synchronised views
    dpci_mech_s mech_w;
    logic       run_w;
    logic       sw_w;
    logic       pwr_w;
    assign mech_w = s2_reg[9:0];
    assign pwr_w  = s2_reg[10];
    assign sw_w   = s2_reg[11];
    assign run_w  = s2_reg[12];

    // Sequencer and latches
    dpci_seq_e   state_reg;
    dpci_seq_e   state_next;
    logic        prot_reg;
    logic        fault_reg;
    logic        saw_load_reg;  // Load position seen since last run
    logic        deb_reg;       // Debounced switch level
    logic [CW-1:0] deb_cnt_reg;
    dpci_cmd_s   cmd_reg;
    dpci_lamps_s lamps_reg;

    // Debounce: level accepted once stable for the whole window
    logic deb_diff_w;
    logic deb_done_w;
    logic press_w;
    assign deb_diff_w = (sw_w != deb_reg);
    assign deb_done_w = (deb_cnt_reg == CW'(DEBOUNCE_CYC - 1));
    assign press_w = deb_diff_w && deb_done_w && sw_w;

    // Recycle: entering run after load was selected
    logic recycle_w;
    assign recycle_w = saw_load_reg && run_w;

    // Fault sources
    logic fault_src_w;
    assign fault_src_w = ((mech_w.erase_current || mech_w.write_current) && !write_gate_in)
                         || mech_w.transducer_fail;

    // Lamp conditions
    logic ready_w;
    assign ready_w = run_w && (state_reg == DPCI_RUNNING) && mech_w.at_speed
                     && mech_w.heads_loaded && mech_w.interlocks_safe;

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DPCI_IDLE, DPCI_STOPPED: begin
                if (run_w && mech_w.interlocks_safe) begin
                    state_next = DPCI_SPIN_UP;
                end
            end
            DPCI_SPIN_UP: begin
                if (!run_w) begin
                    state_next = DPCI_SPIN_DOWN;
                end else if (mech_w.at_speed) begin
                    state_next = DPCI_HEAD_LOAD;
                end
            end
            DPCI_HEAD_LOAD: begin
                if (!run_w) begin
                    state_next = DPCI_SPIN_DOWN;
                end else if (mech_w.heads_loaded) begin
                    state_next = DPCI_RUNNING;
                end
            end
            DPCI_RUNNING: begin
                if (!run_w) begin
                    state_next = DPCI_SPIN_DOWN;
                end
            end
            DPCI_SPIN_DOWN: begin
                // unlock only once stopped and retracted
                if (mech_w.stopped && mech_w.heads_retracted) begin
                    state_next = DPCI_STOPPED;
                end
            end
            // Unused codes: spin down, door stays locked until stopped
            default: begin
                state_next = DPCI_SPIN_DOWN;
            end
        endcase
    end

    // Synchronisers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else if (ce_in) begin
            s1_reg <= async_w;
            s2_reg <= s1_reg;
        end
    end

    // Debounce counter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            deb_cnt_reg <= '0;
            deb_reg     <= 1'b0;
        end else if (ce_in) begin
            if (!deb_diff_w) begin
                deb_cnt_reg <= '0;
            end else if (deb_done_w) begin
                deb_cnt_reg <= '0;
                deb_reg     <= sw_w;
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 1'b1;
            end
        end
    end

    // Sequencer state and load memory
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg    <= DPCI_IDLE;
            saw_load_reg <= 1'b0;
        end else if (ce_in) begin
            state_reg <= state_next;
            if (!run_w) begin
                saw_load_reg <= 1'b1;
            end else begin
                saw_load_reg <= 1'b0;
            end
        end
    end

    // Write protection latch; setting wins over clearing
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prot_reg <= `DPCI_PROT_RST;
        end else if (ce_in) begin
            if (host_protect_in) begin
                prot_reg <= 1'b1;
            end else if (press_w) begin
                prot_reg <= !prot_reg;
            end else if (recycle_w) begin
                prot_reg <= 1'b0;
            end
        end
    end

    // Fault latch; a new fault wins over the clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fault_reg <= 1'b0;
        end else if (ce_in) begin
            if (fault_src_w) begin
                fault_reg <= 1'b1;
            end else if (press_w || recycle_w) begin
                fault_reg <= 1'b0;
            end
        end
    end

    // Mechanics commands, registered
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_reg <= '0;
        end else if (ce_in) begin
            // door locked and spindle on while running up or run
            cmd_reg.door_lock  <= (state_next != DPCI_IDLE) && (state_next != DPCI_STOPPED);
            cmd_reg.spindle_on <= (state_next == DPCI_SPIN_UP) ||
                                  (state_next == DPCI_HEAD_LOAD) ||
                                  (state_next == DPCI_RUNNING);
            cmd_reg.heads_forward <= (state_next == DPCI_HEAD_LOAD);
            cmd_reg.heads_unload  <= (state_next == DPCI_SPIN_DOWN);
        end
    end

    // Lamps, registered
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lamps_reg <= '0;
        end else if (ce_in) begin
            lamps_reg.ready <= ready_w;
            lamps_reg.heads_settled_lamp <= ready_w && !mech_w.seek_busy
                                            && mech_w.heads_settled;
            lamps_reg.fault   <= fault_reg;
            lamps_reg.protect <= prot_reg;
            lamps_reg.load <= mech_w.heads_retracted && mech_w.stopped;
            lamps_reg.write_activity_lamp <= write_gate_in;
            lamps_reg.read_activity <= read_active_in;
            lamps_reg.power_present_lamp <= pwr_w;
        end
    end

    assign cmd_out   = cmd_reg;
    assign lamps_out = lamps_reg;

    // ready lamp never lit without speed
    chk_ready_speed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && lamps_reg.ready |-> $past(mech_w.at_speed) && $past(mech_w.heads_loaded))
        else $error("ready lamp lit without speed or heads");

    // ready lamp off after load selected
    chk_ready_load_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && !run_w |=> !lamps_reg.ready || !ce_in)
        else $error("ready lamp stayed on in load");

    chk_oncyl_seek: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && mech_w.seek_busy |=> !lamps_reg.heads_settled_lamp || !ce_in)
        else $error("on-cylinder lamp lit during seek");

    chk_host_prot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && host_protect_in ##1 ce_in |=> lamps_reg.protect)
        else $error("host protect did not light lamp");

    chk_press_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && press_w && !host_protect_in |=> prot_reg != $past(prot_reg))
        else $error("press did not toggle protection");

    chk_fault_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && fault_src_w |=> fault_reg)
        else $error("fault not latched");

    chk_fault_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fault_reg && !(ce_in && (press_w || recycle_w)) |=> fault_reg)
        else $error("fault dropped without clear");

    chk_door_unlock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && state_reg == DPCI_SPIN_DOWN ##1 ce_in && state_reg == DPCI_STOPPED
        |=> !cmd_reg.door_lock || state_reg != DPCI_STOPPED)
        else $error("door not released after stop");

    chk_write_lamp: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in |=> lamps_reg.write_activity_lamp == $past(write_gate_in))
        else $error("write lamp mismatch");

    chk_fault_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && press_w && !fault_src_w |=> !fault_reg)
        else $error("press did not clear fault");

    chk_recycle_prot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && recycle_w && !host_protect_in && !press_w |=> !prot_reg)
        else $error("recycle did not clear protection");

    // load lamp tracks retract and stop
    chk_load_lamp: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in |=> lamps_reg.load == ($past(mech_w.heads_retracted) && $past(mech_w.stopped)))
        else $error("load lamp mismatch");

    chk_power_lamp: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in |=> lamps_reg.power_present_lamp == $past(pwr_w))
        else $error("power lamp mismatch");

    // door locked, spindle on in run
    chk_door_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && state_reg == DPCI_RUNNING |-> cmd_reg.door_lock && cmd_reg.spindle_on)
        else $error("door or spindle off while running");

    chk_heads_fwd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && state_reg == DPCI_HEAD_LOAD |-> cmd_reg.heads_forward)
        else $error("heads not driven forward in head load");

    chk_oncyl_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lamps_reg.heads_settled_lamp |-> lamps_reg.ready)
        else $error("on-cylinder lamp lit without ready");

    // one press pulse per accepted rising edge
    chk_press_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && press_w |=> !press_w)
        else $error("press pulse lasted more than one cycle");

endmodule // dpci_panel

// [dpci_mech_model.sv]
/*
 * Behavioural spindle and carriage model for the panel bench.
 * Assumes panel commands on clk_in; motion takes fixed cycle counts.
 */
`timescale 1ns/1ps
module dpci_mech_model
    import dpci_pkg::*;
#(
    parameter int SPIN_CYC = 20 // Cycles to reach or lose speed
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Panel commands and bench faults
    input  wire dpci_cmd_s  cmd_in,
    input  wire logic [4:0] stim_in, // Safe, seek, lamp fail, erase, write
    // Status back to the panel
    output dpci_mech_s      mech_out
);
    int spd_reg; // Spindle speed count
    int hd_reg;  // Head travel count, 10 means loaded

    // Motion; heads only advance onto a disk at speed
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            spd_reg <= 0;
            hd_reg  <= 0;
        end else begin
            if (cmd_in.spindle_on && spd_reg < SPIN_CYC) spd_reg <= spd_reg + 1;
            else if (!cmd_in.spindle_on && spd_reg > 0) spd_reg <= spd_reg - 1;
            if (cmd_in.heads_forward && spd_reg == SPIN_CYC && hd_reg < 10) begin
                hd_reg <= hd_reg + 1;
            end else if (cmd_in.heads_unload && hd_reg > 0) begin
                hd_reg <= hd_reg - 1;
            end
        end
    end

    // Status lines; a seeking carriage is never settled
    assign mech_out = {stim_in[4], spd_reg == SPIN_CYC, spd_reg == 0, hd_reg == 10,
                       hd_reg == 0, stim_in[3], hd_reg == 10 && !stim_in[3], stim_in[2:0]};
endmodule // dpci_mech_model

// [dpci_panel_tb.sv]
/*
 * Self-checking bench for the panel sequencing and lamps.
 * Assumes the mechanics model on the far side; short debounce count.
 */
`timescale 1ns/1ps
module dpci_panel_tb;
    import dpci_pkg::*;
    logic        clk_in, rst_n_in, ce_in; // Clock, reset, enable
    logic        run_sel, wit, power_ok;  // Panel inputs
    logic        host_prot, wg, rd;       // Host and data path
    logic [4:0]  stim;                    // Fault and seek stimulus
    logic        fwd_seen;                // Heads driven forward
    dpci_mech_s  mech;                    // Model status
    dpci_cmd_s   cmd;                     // Panel commands
    dpci_lamps_s lamps;                   // Lamp bundle
    int          fails, num_checks, cyc;  // Counters

    dpci_panel #(.DEBOUNCE_CYC(4)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .run_sel_in(run_sel), .write_inhibit_toggle_in(wit), .mech_in(mech),
        .power_ok_in(power_ok), .host_protect_in(host_prot), .write_gate_in(wg),
        .read_active_in(rd), .cmd_out(cmd), .lamps_out(lamps));
    dpci_mech_model mech_m (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd),
        .stim_in(stim), .mech_out(mech));

    // 40 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Head-load watch and hang limit
    always @(posedge clk_in) begin
        if (!rst_n_in) fwd_seen <= 1'b0;
        else if (cmd.heads_forward === 1'b1) fwd_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // Wait, bounded, for a lamp bit, then compare it
    task automatic wait_lamp(input int i, input logic v);
        int k;
        k = 0;
        while (lamps[i] !== v && k < 300) begin
            tick(1);
            k++;
        end
        check(lamps[i], v);
    endtask

    // Clean press, long enough to pass the debounce
    task automatic press();
        wit = 1'b1;
        tick(12);
        wit = 1'b0;
        tick(12);
    endtask

    initial begin
        cyc = 0; fails = 0; num_checks = 0;
        rst_n_in = 1'b0; ce_in = 1'b1; run_sel = 1'b0; wit = 1'b0; power_ok = 1'b0;
        host_prot = 1'b0; wg = 1'b0; rd = 1'b0; stim = 5'h00;
        tick(16);
        check(lamps, 8'h00);
        rst_n_in = 1'b1;
        power_ok = 1'b1;
        wait_lamp(0, 1'b1);
        // Run with an unsafe interlock must stay idle
        run_sel = 1'b1;
        tick(40);
        check(cmd.spindle_on, 1'b0);
        check(lamps.ready, 1'b0);
        stim = 5'h10;
        wait_lamp(7, 1'b1);
        check(cmd.door_lock, 1'b1);
        check(fwd_seen, 1'b1);
        wait_lamp(6, 1'b1);
        stim = 5'h18;
        wait_lamp(6, 1'b0);
        stim = 5'h10;
        wait_lamp(6, 1'b1);
        stim = 5'h00;
        wait_lamp(7, 1'b0);
        stim = 5'h10;
        wait_lamp(7, 1'b1);
        // Enable low freezes the lamps; the gate shows once it returns
        ce_in = 1'b0;
        // Write current under a gate is no fault; without one it is
        wg = 1'b1;
        tick(4);
        check(lamps.write_activity_lamp, 1'b0);
        check(lamps.ready, 1'b1);
        ce_in = 1'b1;
        wait_lamp(2, 1'b1);
        rd = 1'b1;
        wait_lamp(1, 1'b1);
        stim = 5'h11;
        tick(8);
        check(lamps.fault, 1'b0);
        wg = 1'b0;
        wait_lamp(2, 1'b0);
        wait_lamp(5, 1'b1);
        stim = 5'h10;
        rd = 1'b0;
        wait_lamp(1, 1'b0);
        press();
        wait_lamp(4, 1'b1);
        wait_lamp(5, 1'b0);
        press();
        wait_lamp(4, 1'b0);
        // A bounce shorter than the debounce does nothing
        wit = 1'b1;
        tick(2);
        wit = 1'b0;
        tick(12);
        check(lamps.protect, 1'b0);
        host_prot = 1'b1;
        tick(1);
        host_prot = 1'b0;
        wait_lamp(4, 1'b1);
        stim = 5'h14;
        tick(3);
        stim = 5'h10;
        wait_lamp(5, 1'b1);
        tick(20);
        check(lamps.fault, 1'b1);
        // Load, then run again to recycle; door held until stopped
        run_sel = 1'b0;
        tick(4);
        check(lamps.ready, 1'b0);
        check(lamps.load, 1'b0);
        check(cmd.heads_unload, 1'b1);
        check(cmd.door_lock, 1'b1);
        wait_lamp(3, 1'b1);
        check(cmd.door_lock, 1'b0);
        check({mech.stopped, mech.heads_retracted}, 8'h03);
        run_sel = 1'b1;
        wait_lamp(7, 1'b1);
        check(lamps.protect, 1'b0);
        check(lamps.fault, 1'b0);
        power_ok = 1'b0;
        wait_lamp(0, 1'b0);
        finish_test();
    end
endmodule // dpci_panel_tb
